/* File: hdl/ied_pkg.sv */
// Behaviour
// RULE1 - Handler pointer comes from a 256-entry table at vector times four.
// RULE2 - Entry pushes status word, code segment and return offset on the stack.
// RULE3 - Hardware requests sampled only at boundaries; instruction exceptions go first.
// RULE4 - Entry clears the enable flag; saved status word keeps the prior value.
// RULE5 - Interrupt return restores flags; a pending request is served at once.
// RULE6 - Divide overflow raises type 0.
// RULE7 - Trace flag raises type 1, not after prefix, segment write or wait.
// RULE8 - Non-maskable request ignores the enable flag, vector 2, no acknowledge.
// RULE9 - Breakpoint opcode is type 3, pointer at table byte offset 12.
// RULE10 - Overflow trap instruction raises type 4 only with the overflow flag.
// RULE11 - Bounds check outside the memory limits raises type 5.
// RULE12 - Undefined opcode raises type 6.
// RULE13 - Escape opcodes D8 to DF raise type 7 only with escape trap bit.
// RULE14 - Escape trap returns to the escape opcode; others to the next instruction.
// RULE15 - Pins, DMA and timer requests accepted only with the enable flag set.
// RULE16 - Vectors: timers 8, 18, 19; DMA 10, 11; pins 12 to 15.
// RULE17 - Default priorities used unless software programs unique levels.
// RULE18 - Timers share one level, ranked timer 0 over 1 over 2.
// RULE19 - Cascaded pin requests take an 8-bit vector during acknowledge.
// RULE20 - Software interrupt reaches any of 256 vectors; 0 to 31 reserved.
// RULE21 - Single-step service clears the trace flag.
// RULE22 - Load offset from first table word, segment from second, then fetch.
package ied_pkg;
   localparam int unsigned IED_TR_BIT = 8;
   localparam int unsigned IED_IF_BIT = 9;
   localparam int unsigned IED_OV_BIT = 11;
   localparam logic [7:0] IED_VEC_DIV  = 8'h00;
   localparam logic [7:0] IED_VEC_STEP = 8'h01;
   localparam logic [7:0] IED_VEC_NMI  = 8'h02;
   localparam logic [7:0] IED_VEC_BRK  = 8'h03;
   localparam logic [7:0] IED_VEC_OVF  = 8'h04;
   localparam logic [7:0] IED_VEC_BND  = 8'h05;
   localparam logic [7:0] IED_VEC_UND  = 8'h06;
   localparam logic [7:0] IED_VEC_COP  = 8'h07;
   localparam logic [7:0] IED_VEC_TMR0 = 8'h08;
   localparam logic [7:0] IED_VEC_DMA0 = 8'h0a;
   localparam logic [7:0] IED_VEC_DMA1 = 8'h0b;
   localparam logic [7:0] IED_VEC_EXT0 = 8'h0c;
   localparam logic [7:0] IED_VEC_TMR1 = 8'h12;
   localparam logic [7:0] IED_VEC_TMR2 = 8'h13;
   localparam logic [7:0] IED_COP_LO   = 8'hd8;
   localparam logic [7:0] IED_COP_HI   = 8'hdf;
   localparam logic [3:0] IED_REG_CTRL = 4'h0;
   localparam logic [3:0] IED_REG_PRIO = 4'h4;
   localparam logic [3:0] IED_REG_STAT = 4'h8;
   localparam int unsigned IED_CTRL_COP  = 0;
   localparam int unsigned IED_CTRL_CASC = 1;
   localparam logic [1:0]  IED_CTRL_RST  = 2'h0;
   localparam logic [20:0] IED_PRIO_RST  = 21'h00000;
   localparam int unsigned IED_NSRC      = 7;
   localparam int unsigned IED_LVLW      = 3;
   localparam int unsigned IED_SRC_EXT0  = 3;

   typedef enum logic [2:0] {
      IED_IDLE, IED_ACK, IED_PUSHF, IED_PUSHCS, IED_PUSHIP, IED_RDIP, IED_RDCS
   } ied_state_e;

   typedef struct packed {
      logic [3:0]  addr;
      logic [31:0] wdata;
      logic        we;
      logic        re;
   } ied_bus_s;

   typedef struct packed {
      logic        boundary;
      logic        isRtn;
      logic        prefix;
      logic        segWrite;
      logic        waitOp;
      logic        divErr;
      logic        undefOp;
      logic        intoOp;
      logic        brkOp;
      logic        intOp;
      logic        boundOp;
      logic [7:0]  opcode;
      logic [7:0]  intType;
      logic [15:0] nextIp;
      logic [15:0] copIp;
      logic [15:0] index;
      logic [15:0] lower;
      logic [15:0] upper;
      logic [15:0] rtnFlags;
   } ied_retire_s;

   typedef struct packed {
      ied_state_e  st;
      logic [7:0]  vec;
      logic [15:0] svFlags;
      logic [15:0] retIp;
      logic [15:0] retCs;
      logic [15:0] newIp;
      logic [1:0]  ctrl;
      logic [20:0] prio;
      logic [31:0] rdata;
      logic [1:0]  nmiSync;
      logic        nmiPrev;
      logic        nmiPend;
      logic [3:0]  extS1;
      logic [3:0]  extS2;
      logic        busy;
      logic        pushReq;
      logic [15:0] pushData;
      logic        rdReq;
      logic [9:0]  rdAddr;
      logic        intaReq;
      logic        jump;
      logic [15:0] jmpIp;
      logic [15:0] jmpCs;
      logic [15:0] flags;
      logic [8:0]  srcAck;
      logic [7:0]  lastVec;
   } ied_state_s;
endpackage

/* File: hdl/ied_dispatch.sv */
`timescale 1ns/1ps
`default_nettype none
module ied_dispatch
   import ied_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // Register port
   input  wire ied_bus_s    bus,
   output logic [31:0]      busRdata,
   // Retiring instruction
   input  wire ied_retire_s retire,
   input  wire logic [15:0] statusWord,
   input  wire logic [15:0] codeSeg,
   // Request sources
   input  wire logic        nmiPin,
   input  wire logic [3:0]  extReqPin,
   input  wire logic [2:0]  timerReq,
   input  wire logic [1:0]  dmaReq,
   output logic [8:0]       srcAck,
   // Acknowledge sequence
   output logic             intaReq,
   input  wire logic        ackValid,
   input  wire logic [7:0]  ackVector,
   // Stack writes
   output logic             pushReq,
   output logic [15:0]      pushData,
   input  wire logic        pushAck,
   // Table reads
   output logic             rdReq,
   output logic [9:0]       rdAddr,
   input  wire logic        rdAck,
   input  wire logic [15:0] rdData,
   // Redirect
   output logic             busy,
   output logic             jumpValid,
   output logic [15:0]      jumpIp,
   output logic [15:0]      jumpCs,
   output logic [15:0]      flagsOut
);

   ied_state_s  q;
   ied_state_s  d;
   logic        atBoundary;
   logic [15:0] effFlags;
   logic        boundFail;
   logic        copHit;
   logic        copTaken;
   logic        swExc;
   logic [7:0]  swVec;
   logic [6:0]  srcPend;
   logic        lvlUq;
   logic        found;
   logic [2:0]  best;
   logic [2:0]  bestLvl;
   logic [7:0]  hwVec;
   logic [8:0]  hwAck;
   logic        hwOk;
   logic        stepOk;

   function automatic logic lvlUnique(input logic [20:0] p);
      logic u;
      u = 1'b1;
      for (int i = 0; i < IED_NSRC; i++) begin
         for (int j = i + 1; j < IED_NSRC; j++) begin
            if (p[i*IED_LVLW +: IED_LVLW] == p[j*IED_LVLW +: IED_LVLW]) begin
               u = 1'b0;
            end
         end
      end
      return u;
   endfunction

   // Source order doubles as the default ranking
   function automatic logic [2:0] srcLevel(input logic [20:0] p,
                                           input logic uq,
                                           input int unsigned i);
      return uq ? p[i*IED_LVLW +: IED_LVLW] : 3'(i);
   endfunction

   always_comb begin
      // A prefix is not a boundary: nothing may split it from its opcode
      atBoundary = retire.boundary && !retire.prefix; // RULE3
      effFlags = retire.isRtn ? retire.rtnFlags : statusWord; // RULE5
      boundFail = retire.boundOp &&
                  (($signed(retire.index) < $signed(retire.lower)) ||
                   ($signed(retire.index) > $signed(retire.upper))); // RULE11
      copHit = (retire.opcode >= IED_COP_LO) &&
               (retire.opcode <= IED_COP_HI) &&
               q.ctrl[IED_CTRL_COP]; // RULE13
      copTaken = copHit && !retire.divErr && !retire.undefOp;
      swExc = 1'b1;
      swVec = IED_VEC_DIV;
      if (retire.divErr) begin
         swVec = IED_VEC_DIV; // RULE6
      end else if (retire.undefOp) begin
         swVec = IED_VEC_UND; // RULE12
      end else if (copHit) begin
         swVec = IED_VEC_COP; // RULE13
      end else if (retire.intoOp && statusWord[IED_OV_BIT]) begin
         swVec = IED_VEC_OVF; // RULE10
      end else if (boundFail) begin
         swVec = IED_VEC_BND; // RULE11
      end else if (retire.brkOp) begin
         swVec = IED_VEC_BRK; // RULE9
      end else if (retire.intOp) begin
         swVec = retire.intType; // RULE20
      end else begin
         swExc = 1'b0;
      end

      srcPend = {q.extS2, dmaReq, |timerReq}; // RULE18
      lvlUq = lvlUnique(q.prio); // RULE17
      found = 1'b0;
      best = 3'h0;
      bestLvl = 3'h0;
      // Strict compare keeps the lower source index on a tie
      for (int unsigned i = 0; i < IED_NSRC; i++) begin
         if (srcPend[i] &&
             (!found || srcLevel(q.prio, lvlUq, i) < bestLvl)) begin
            found = 1'b1;
            best = 3'(i);
            bestLvl = srcLevel(q.prio, lvlUq, i); // RULE17
         end
      end

      hwAck = '0;
      hwVec = IED_VEC_TMR0;
      if (best == 3'h0) begin
         if (timerReq[0]) begin
            hwVec = IED_VEC_TMR0; // RULE18
            hwAck[0] = 1'b1;
         end else if (timerReq[1]) begin
            hwVec = IED_VEC_TMR1;
            hwAck[1] = 1'b1;
         end else begin
            hwVec = IED_VEC_TMR2;
            hwAck[2] = 1'b1;
         end
      end else begin
         hwAck[int'(best) + 2] = 1'b1;
         if (best == 3'h1) begin
            hwVec = IED_VEC_DMA0; // RULE16
         end else if (best == 3'h2) begin
            hwVec = IED_VEC_DMA1;
         end else begin
            hwVec = IED_VEC_EXT0 + 8'(best - 3'(IED_SRC_EXT0)); // RULE16
         end
      end
      hwOk = effFlags[IED_IF_BIT] && found; // RULE15

      stepOk = statusWord[IED_TR_BIT] &&
               !retire.segWrite && !retire.waitOp; // RULE7
   end

   always_comb begin
      logic take;
      logic casc;
      take = 1'b0;
      casc = 1'b0;
      d = q;
      d.jump = 1'b0;
      d.srcAck = '0;
      d.rdata = '0;
      // The first stage is read only by the second
      d.nmiSync = {q.nmiSync[0], nmiPin};
      d.nmiPrev = q.nmiSync[1];
      d.extS1 = extReqPin;
      d.extS2 = q.extS1;

      if (bus.we) begin
         case (bus.addr)
            IED_REG_CTRL: d.ctrl = bus.wdata[1:0];
            IED_REG_PRIO: d.prio = bus.wdata[20:0];
            default: ;
         endcase
      end
      if (bus.re) begin
         case (bus.addr)
            IED_REG_CTRL: d.rdata = {30'h0, q.ctrl};
            IED_REG_PRIO: d.rdata = {11'h0, q.prio};
            IED_REG_STAT: d.rdata = {22'h0, q.nmiPend, q.busy, q.lastVec};
            default:      d.rdata = '0;
         endcase
      end

      unique case (q.st)
         IED_IDLE: begin
            if (atBoundary) begin // RULE3
               take = 1'b1;
               if (swExc) begin
                  d.vec = swVec; // RULE3
               end else if (q.nmiPend) begin
                  d.vec = IED_VEC_NMI; // RULE8
                  d.nmiPend = 1'b0;
               end else if (hwOk) begin
                  d.vec = hwVec; // RULE15
                  d.srcAck = hwAck;
                  casc = q.ctrl[IED_CTRL_CASC] &&
                         (best >= 3'(IED_SRC_EXT0)); // RULE19
               end else if (stepOk) begin
                  d.vec = IED_VEC_STEP; // RULE7
               end else begin
                  take = 1'b0;
               end
            end
            if (take) begin
               d.svFlags = effFlags; // RULE4
               d.retIp = (swExc && copTaken) ? retire.copIp
                                             : retire.nextIp; // RULE14
               d.retCs = codeSeg;
               d.busy = 1'b1;
               if (casc) begin
                  d.st = IED_ACK;
                  d.intaReq = 1'b1; // RULE19
               end else begin
                  d.st = IED_PUSHF;
                  d.pushReq = 1'b1;
                  d.pushData = effFlags; // RULE2
               end
            end
         end
         IED_ACK: begin
            if (ackValid) begin
               d.vec = ackVector; // RULE19
               d.intaReq = 1'b0;
               d.st = IED_PUSHF;
               d.pushReq = 1'b1;
               d.pushData = q.svFlags;
            end
         end
         IED_PUSHF: begin
            if (pushAck) begin
               d.pushData = q.retCs; // RULE2
               d.st = IED_PUSHCS;
            end
         end
         IED_PUSHCS: begin
            if (pushAck) begin
               d.pushData = q.retIp; // RULE2
               d.st = IED_PUSHIP;
            end
         end
         IED_PUSHIP: begin
            if (pushAck) begin
               d.pushReq = 1'b0;
               d.rdReq = 1'b1;
               d.rdAddr = {q.vec, 2'b00}; // RULE1
               d.st = IED_RDIP;
            end
         end
         IED_RDIP: begin
            if (rdAck) begin
               d.newIp = rdData; // RULE22
               d.rdAddr = {q.vec, 2'b10};
               d.st = IED_RDCS;
            end
         end
         IED_RDCS: begin
            if (rdAck) begin
               d.rdReq = 1'b0;
               d.jump = 1'b1; // RULE22
               d.jmpIp = q.newIp;
               d.jmpCs = rdData;
               d.flags = q.svFlags;
               d.flags[IED_IF_BIT] = 1'b0; // RULE4
               d.flags[IED_TR_BIT] = 1'b0; // RULE21
               d.busy = 1'b0;
               d.lastVec = q.vec;
               d.st = IED_IDLE;
            end
         end
      endcase

      // An edge in the cycle of the clear is kept
      if (q.nmiSync[1] && !q.nmiPrev) begin
         d.nmiPend = 1'b1; // RULE8
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         q <= '0;
         q.ctrl <= IED_CTRL_RST;
         q.prio <= IED_PRIO_RST;
      end else begin
         q <= d;
      end
   end

   assign busRdata  = q.rdata;
   assign srcAck    = q.srcAck;
   assign intaReq   = q.intaReq;
   assign pushReq   = q.pushReq;
   assign pushData  = q.pushData;
   assign rdReq     = q.rdReq;
   assign rdAddr    = q.rdAddr;
   assign busy      = q.busy;
   assign jumpValid = q.jump;
   assign jumpIp    = q.jmpIp;
   assign jumpCs    = q.jmpCs;
   assign flagsOut  = q.flags;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   property p_tab_addr;
      (q.st == IED_PUSHIP && pushAck) |=>
         rdReq && rdAddr == {q.vec, 2'b00}
         ##1 (rdAddr == {q.vec, 2'b00} || rdAddr == {q.vec, 2'b10});
   endproperty
   a_tab_addr: assert property (p_tab_addr) // RULE1
      else $error("table address is not vector times four");

   property p_push_seq;
      (q.st == IED_PUSHF && pushAck) |=> pushReq && pushData == q.retCs;
   endproperty
   a_push_seq: assert property (p_push_seq) // RULE2
      else $error("code segment not pushed after status word");

   property p_sw_first;
      (q.st == IED_IDLE && atBoundary && swExc && q.nmiPend) |=>
         q.nmiPend && q.vec == $past(swVec);
   endproperty
   a_sw_first: assert property (p_sw_first) // RULE3
      else $error("instruction exception did not go first");

   property p_save_flags;
      (q.st == IED_IDLE && atBoundary && swExc) |=>
         pushReq && busy && pushData == $past(effFlags);
   endproperty
   a_save_flags: assert property (p_save_flags) // RULE4
      else $error("saved status word differs from prior flags");

   property p_nmi;
      (q.st == IED_IDLE && atBoundary && !swExc && q.nmiPend) |=>
         q.vec == IED_VEC_NMI && !intaReq && pushReq;
   endproperty
   a_nmi: assert property (p_nmi) // RULE8
      else $error("non-maskable request not served on vector 2");

   property p_div;
      (q.st == IED_IDLE && atBoundary && retire.divErr) |=>
         busy && q.vec == IED_VEC_DIV;
   endproperty
   a_div: assert property (p_div) // RULE6
      else $error("divide error did not select type 0");

   property p_step;
      (q.st == IED_IDLE && atBoundary && !swExc && !q.nmiPend &&
       !hwOk && stepOk) |=> q.vec == IED_VEC_STEP && busy;
   endproperty
   a_step: assert property (p_step) // RULE7
      else $error("trace flag did not raise type 1");

   property p_masked;
      (q.st == IED_IDLE && atBoundary && !swExc && !q.nmiPend &&
       !effFlags[IED_IF_BIT] && !stepOk) |=> !busy && !intaReq;
   endproperty
   a_masked: assert property (p_masked) // RULE15
      else $error("maskable request taken with enable flag clear");

   property p_cop_ret;
      (q.st == IED_IDLE && atBoundary && copTaken) |=>
         q.retIp == $past(retire.copIp) && q.vec == IED_VEC_COP;
   endproperty
   a_cop_ret: assert property (p_cop_ret) // RULE14
      else $error("escape trap return address wrong");

   property p_clr_flags;
      jumpValid |-> !flagsOut[IED_IF_BIT] && !flagsOut[IED_TR_BIT] && !busy;
   endproperty
   a_clr_flags: assert property (p_clr_flags) // RULE21
      else $error("enable or trace flag left set at handler entry");

   property p_jump;
      (q.st == IED_RDCS && rdAck) |=>
         jumpValid && jumpCs == $past(rdData) && jumpIp == $past(q.newIp)
         ##1 !jumpValid;
   endproperty
   a_jump: assert property (p_jump) // RULE22
      else $error("handler pointer not loaded from table");

   c_casc: cover property (q.st == IED_ACK && ackValid);
   c_nmi:  cover property (jumpValid && q.lastVec == IED_VEC_NMI);
   c_cop:  cover property (jumpValid && q.lastVec == IED_VEC_COP);
   c_tmr:  cover property (q.srcAck[1] ##[1:40] jumpValid);

endmodule
`default_nettype wire

/* File: verification/ied_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module ied_partner
   import ied_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // Mode
   input  wire logic        slow,
   input  wire logic [7:0]  casVec,
   // Stack
   input  wire logic        pushReq,
   input  wire logic [15:0] pushData,
   output logic             pushAck,
   // Table
   input  wire logic        rdReq,
   input  wire logic [9:0]  rdAddr,
   output logic             rdAck,
   output logic [15:0]      rdData,
   // Acknowledge
   input  wire logic        intaReq,
   output logic             ackValid,
   output logic [7:0]       ackVector
);
   logic [15:0] pushQ[$];
   logic [3:0]  stall;
   logic        go;

   // Slow mode answers once in sixteen cycles
   assign go = !slow || stall == 4'h0;

   // Acks never come twice in a row: the address must move on first
   always @(posedge ref_clk) begin
      if (rst) begin
         pushAck   <= 1'b0;
         rdAck     <= 1'b0;
         ackValid  <= 1'b0;
         rdData    <= 16'h0000;
         ackVector <= 8'h00;
         stall     <= 4'h0;
      end else begin
         stall <= stall + 4'h1;
         if (pushReq && pushAck)
            pushQ.push_back(pushData);
         pushAck  <= pushReq && !pushAck && go;
         rdAck    <= rdReq && !rdAck && go;
         // Released data lines toggle so stale words never look valid
         rdData   <= (rdReq && !rdAck && go) ? {6'h2a, rdAddr} : ~rdData;
         ackValid <= intaReq && !ackValid && go;
         ackVector <= (intaReq && !ackValid && go) ? casVec : ~ackVector;
      end
   end
endmodule
`default_nettype wire

/* File: verification/test_ied_dispatch.sv */
`timescale 1ns/1ps
`default_nettype none
module test_ied_dispatch
   import ied_pkg::*;
();
   localparam logic [10:0] MC [8] = '{11'h007, 11'h206, 11'h218, 11'h390,
                                      11'h380, 11'h224, 11'h401, 11'h100};
   logic        ref_clk, rst, nmiPin, ackValid, pushAck, rdAck;
   logic        intaReq, pushReq, rdReq, busy, jumpValid, slow, clrSrc;
   logic [3:0]  extReqPin;
   logic [2:0]  timerReq;
   logic [1:0]  dmaReq, ctrlV;
   logic [7:0]  ackVector, casVec, lastV;
   logic [8:0]  srcAck, srcSeen;
   logic [9:0]  rdAddr;
   logic [15:0] statusWord, codeSeg, pushData, rdData;
   logic [15:0] jumpIp, jumpCs, flagsOut;
   logic [20:0] prioV;
   logic [31:0] busRdata, rnd;
   ied_bus_s    bus;
   ied_retire_s rt;
   int          errors, checkCount, expSrc;
   bit          copHit, nmiPend;

   ied_dispatch uut (.ref_clk(ref_clk), .rst(rst), .bus(bus),
      .busRdata(busRdata), .retire(rt), .statusWord(statusWord),
      .codeSeg(codeSeg), .nmiPin(nmiPin), .extReqPin(extReqPin),
      .timerReq(timerReq), .dmaReq(dmaReq), .srcAck(srcAck),
      .intaReq(intaReq), .ackValid(ackValid), .ackVector(ackVector),
      .pushReq(pushReq), .pushData(pushData), .pushAck(pushAck),
      .rdReq(rdReq), .rdAddr(rdAddr), .rdAck(rdAck), .rdData(rdData),
      .busy(busy), .jumpValid(jumpValid), .jumpIp(jumpIp),
      .jumpCs(jumpCs), .flagsOut(flagsOut));
   ied_partner partner (.ref_clk(ref_clk), .rst(rst), .slow(slow),
      .casVec(casVec), .pushReq(pushReq), .pushData(pushData),
      .pushAck(pushAck), .rdReq(rdReq), .rdAddr(rdAddr), .rdAck(rdAck),
      .rdData(rdData), .intaReq(intaReq), .ackValid(ackValid),
      .ackVector(ackVector));

   always @(posedge ref_clk)
      srcSeen <= clrSrc ? 9'h000 : srcSeen | srcAck;

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   function automatic ied_retire_s mkr();
      ied_retire_s r;
      rnd = lfsr(rnd);
      r = '0;
      r.nextIp = rnd[15:0];
      r.copIp = rnd[31:16];
      r.opcode = rnd[23:16];
      rnd = lfsr(rnd);
      return r;
   endfunction

   function automatic int expect_vec(ied_retire_s r, logic [15:0] s);
      logic [15:0] f;
      logic [6:0]  rq;
      int          lv[7];
      int          best;
      bit          uniq;
      f = r.isRtn ? r.rtnFlags : s;
      rq = {extReqPin, dmaReq, |timerReq};
      copHit = 0;
      expSrc = -1;
      uniq = 1;
      best = -1;
      for (int i = 0; i < 7; i++) begin
         lv[i] = prioV[3*i +: 3];
         for (int j = 0; j < i; j++)
            if (lv[i] == lv[j]) uniq = 0;
      end
      if (!uniq) foreach (lv[i]) lv[i] = i;
      if (r.prefix) return -1;
      if (r.divErr) return 0;
      if (r.undefOp) return 6;
      if (ctrlV[0] && r.opcode >= 8'hd8 && r.opcode <= 8'hdf) begin
         copHit = 1;
         return 7;
      end
      if (r.intoOp && s[IED_OV_BIT]) return 4;
      if (r.boundOp && ($signed(r.index) < $signed(r.lower) ||
          $signed(r.index) > $signed(r.upper))) return 5;
      if (r.brkOp) return 3;
      if (r.intOp) return r.intType;
      if (nmiPend) return 2;
      if (f[IED_IF_BIT])
         for (int i = 0; i < 7; i++)
            if (rq[i] && (best < 0 || lv[i] < lv[best])) best = i;
      if (best == 0) begin
         expSrc = timerReq[0] ? 0 : timerReq[1] ? 1 : 2;
         return expSrc == 0 ? 8 : expSrc == 1 ? 18 : 19;
      end
      if (best > 0) begin
         expSrc = best + 2;
         if (best > 2 && ctrlV[1]) return casVec;
         return best == 1 ? 10 : best == 2 ? 11 : best + 9;
      end
      if (s[IED_TR_BIT] && !r.segWrite && !r.waitOp) return 1;
      return -1;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checkCount++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      if (a == IED_REG_CTRL) ctrlV = d[1:0];
      if (a == IED_REG_PRIO) prioV = d[20:0];
      @(posedge ref_clk);
      bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
      @(posedge ref_clk);
      bus.we <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      @(posedge ref_clk);
      bus <= '{addr: a, wdata: 32'h0, we: 1'b0, re: 1'b1};
      @(posedge ref_clk);
      bus.re <= 1'b0;
      #1;
      chk(busRdata, exp);
   endtask

   task automatic setreq(input logic [2:0] t, input logic [1:0] d,
                         input logic [3:0] p, input logic nm);
      @(posedge ref_clk);
      timerReq <= t;
      dmaReq <= d;
      extReqPin <= p;
      nmiPin <= nm;
      if (nm) nmiPend = 1;
      // Pins pass a two-flop synchroniser, the NMI edge one flop more
      repeat (4) @(posedge ref_clk);
      nmiPin <= 1'b0;
   endtask

   task automatic run(input ied_retire_s r, input logic [15:0] s);
      int          ev;
      int          n;
      logic [15:0] f;
      logic [15:0] cs;
      ev = expect_vec(r, s);
      f = r.isRtn ? r.rtnFlags : s;
      cs = rnd[31:16];
      n = 0;
      r.boundary = 1'b1;
      @(posedge ref_clk);
      rt <= r;
      statusWord <= s;
      codeSeg <= cs;
      clrSrc <= 1'b1;
      @(posedge ref_clk);
      rt.boundary <= 1'b0;
      clrSrc <= 1'b0;
      if (ev < 0) begin
         repeat (12) @(posedge ref_clk);
         #1;
         chk(partner.pushQ.size(), 0);
         chk(busy, 1'b0);
         return;
      end
      do begin
         @(posedge ref_clk);
         #1;
         n++;
      end while (jumpValid !== 1'b1 && n < 300);
      if (ev == 2) nmiPend = 0;
      lastV = 8'(ev);
      chk(jumpValid, 1'b1);
      chk(jumpIp, {6'h2a, 10'(ev * 4)});
      chk(jumpCs, {6'h2a, 10'(ev * 4 + 2)});
      chk(flagsOut, f & 16'hfcff);
      chk(srcSeen, expSrc < 0 ? 9'h000 : 9'h001 << expSrc);
      chk(partner.pushQ.size(), 3);
      if (partner.pushQ.size() == 3) begin
         chk(partner.pushQ[0], f);
         chk(partner.pushQ[1], cs);
         chk(partner.pushQ[2], copHit ? r.copIp : r.nextIp);
      end
      partner.pushQ.delete();
   endtask

   task automatic conclude();
      $display("Comparisons %0d mismatches %0d", checkCount, errors);
      if (errors == 0 && checkCount > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   initial begin
      repeat (40000) @(posedge ref_clk);
      errors++;
      conclude();
   end

   initial begin : main
      ied_retire_s r;
      logic [15:0] s;
      {rst, bus, rt, statusWord, codeSeg} = '1;
      {bus, rt, statusWord, codeSeg, nmiPin, extReqPin} = '0;
      {timerReq, dmaReq, slow, casVec, clrSrc, ctrlV, prioV} = '0;
      {errors, checkCount, nmiPend, lastV} = '0;
      rnd = 32'h633e64f4;
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      rd(IED_REG_STAT, 32'h0);
      rd(4'hc, 32'h0);
      wr(4'hc, 32'hffffffff);
      wr(IED_REG_CTRL, 32'h1);
      rd(IED_REG_CTRL, 32'h1);
      for (int k = 0; k < 8; k++) begin
         r = mkr();
         s = rnd[31:16];
         case (k)
            0: {r.divErr, r.undefOp, r.brkOp} = 3'b111;
            1: r.undefOp = 1'b1;
            2: r.opcode = 8'hd8 | {5'h0, rnd[2:0]};
            3: {r.intoOp, s[IED_OV_BIT]} = 2'b11;
            4: {r.boundOp, r.index, r.upper} = {1'b1, 16'd100, 16'd50};
            5: {r.intOp, r.intType} = {1'b1, rnd[7:0]};
            default: r.brkOp = 1'b1;
         endcase
         slow <= k[0];
         run(r, s);
      end
      rd(IED_REG_STAT, {24'h0, lastV});
      wr(IED_REG_CTRL, 32'h0);
      for (int k = 0; k < 8; k++) begin
         r = mkr();
         s = rnd[31:16] & 16'hf6ff;
         s[IED_TR_BIT] = k > 3;
         case (k)
            0: r.opcode = 8'hdc;
            1: r.intoOp = 1'b1;
            2: {r.boundOp, r.index, r.lower, r.upper} =
               {1'b1, 16'd20, 16'hfff6, 16'd30};
            3: {r.prefix, r.divErr} = 2'b11;
            4: r.segWrite = 1'b1;
            5: r.waitOp = 1'b1;
            6: r.opcode = 8'h90;
            default: r.prefix = 1'b1;
         endcase
         run(r, s);
      end
      for (int m = 0; m < 8; m++) begin
         r = mkr();
         s = (rnd[31:16] & 16'hfcff) | {6'h0, MC[m][9], 9'h0};
         // A breakpoint goes ahead of the NMI, which waits for the next one
         r.brkOp = MC[m][10];
         setreq(MC[m][2:0], MC[m][4:3], MC[m][8:5], MC[m][10]);
         run(r, s);
         setreq(3'h0, 2'h0, 4'h0, 1'b0);
      end
      wr(IED_REG_PRIO, 32'h0000a72e);
      rd(IED_REG_PRIO, 32'h0000a72e);
      r = mkr();
      setreq(3'h1, 2'h0, 4'h9, 1'b0);
      run(r, 16'h0200);
      setreq(3'h0, 2'h0, 4'h0, 1'b0);
      wr(IED_REG_PRIO, 32'h0);
      wr(IED_REG_CTRL, 32'h2);
      casVec <= 8'h5a;
      slow <= 1'b1;
      r = mkr();
      setreq(3'h0, 2'h0, 4'h2, 1'b0);
      run(r, 16'h0200);
      setreq(3'h0, 2'h0, 4'h0, 1'b0);
      wr(IED_REG_CTRL, 32'h0);
      r = mkr();
      r.isRtn = 1'b1;
      r.rtnFlags = (rnd[15:0] & 16'hfcff) | 16'h0200;
      setreq(3'h4, 2'h0, 4'h0, 1'b0);
      run(r, rnd[31:16] & 16'hfcff);
      setreq(3'h0, 2'h0, 4'h0, 1'b0);
      rd(IED_REG_STAT, {24'h0, lastV});
      conclude();
   end
endmodule
`default_nettype wire
